// ### rtl/pwm_unit.v
`timescale 1ns/1ps
`include "pwm_unit_defs.vh"
`default_nettype none
module pwm_unit #(
    parameter NUM_GEN = 4,
    parameter WIDTH = 16
) (
    // clock and reset
    input wire clk,
    input wire rstn,
    // axi4-lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // fault inputs
    input wire [3:0] external_fault_input,
    // pins and events
    output reg [2*NUM_GEN-1:0] pulse_out,
    output wire [NUM_GEN-1:0] gen_interrupt,
    output wire [NUM_GEN-1:0] gen_trigger,
    output reg fault_pending
);
    // write-strobe merge of one 32-bit word
    function [31:0] merge_word;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0] strb;
        integer k;
        begin
            merge_word = old_val;
            for (k = 0; k < 4; k = k + 1) begin
                if (strb[k]) begin
                    merge_word[8*k +: 8] = new_val[8*k +: 8];
                end
            end
        end
    endfunction

    // address decode shared by the read and write paths
    function addr_mapped;
        input [7:0] a;
        begin
            addr_mapped = (a[1:0] == 2'b00) &&
                ((a <= `OFS_TRIG_SEL) ||
                 (a >= `OFS_COUNT_BASE && a < `OFS_COUNT_BASE + 4 * NUM_GEN) ||
                 (a >= `OFS_GEN_BASE && a <= `OFS_GEN_LAST && a[5:4] < NUM_GEN));
        end
    endfunction

    reg [`CTRL_WIDTH-1:0] ctrl;
    reg [2*NUM_GEN-1:0] invert;
    reg [2*NUM_GEN-1:0] out_en;
    reg [15:0] trig_sel;
    reg [3:0] fault_stat;
    reg [WIDTH*NUM_GEN-1:0] load_v, cmpa_v, cmpb_v, rise_v, fall_v;
    reg [NUM_GEN-1:0] sync_pulse;

    reg [7:0] aw_addr;
    reg aw_held;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg w_held;

    wire [WIDTH*NUM_GEN-1:0] count_v;
    wire [NUM_GEN-1:0] cmp_a, cmp_b;
    wire [2*NUM_GEN-1:0] pair_raw;
    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire [5:0] gen_base = {aw_addr[5:4], 4'h0};
    wire wr_gen = do_write && aw_addr >= `OFS_GEN_BASE && aw_addr <= `OFS_GEN_LAST
        && aw_addr[5:4] < NUM_GEN;
    wire [31:0] w_lane = merge_word(32'h00000000, w_data, w_strb);
    // byte lanes kept from the old value are the ones whose strobe is low
    wire [31:0] w_mask = merge_word(32'h00000000, 32'hffffffff, w_strb);

    // write channel: address and data accepted in either order
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= addr_mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // configuration registers
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl <= `RST_CTRL;
            invert <= `RST_INVERT;
            out_en <= `RST_OUT_EN;
            trig_sel <= `RST_TRIG_SEL;
            load_v <= {NUM_GEN{`RST_WORD16}};
            cmpa_v <= {NUM_GEN{`RST_WORD16}};
            cmpb_v <= {NUM_GEN{`RST_WORD16}};
            rise_v <= {NUM_GEN{`RST_WORD16}};
            fall_v <= {NUM_GEN{`RST_WORD16}};
            sync_pulse <= {NUM_GEN{1'b0}};
        end else begin
            sync_pulse <= {NUM_GEN{1'b0}};
            if (do_write) begin
                case (aw_addr)
                    `OFS_CTRL: ctrl <= (ctrl & ~w_mask[`CTRL_WIDTH-1:0]) | w_lane[`CTRL_WIDTH-1:0];
                    `OFS_SYNC: sync_pulse <= w_lane[NUM_GEN-1:0];
                    `OFS_INVERT: invert <= (invert & ~w_mask[2*NUM_GEN-1:0]) | w_lane[2*NUM_GEN-1:0];
                    `OFS_OUT_EN: out_en <= (out_en & ~w_mask[2*NUM_GEN-1:0]) | w_lane[2*NUM_GEN-1:0];
                    `OFS_TRIG_SEL: trig_sel <= (trig_sel & ~w_mask[15:0]) | w_lane[15:0];
                    default: ;
                endcase
            end
            if (wr_gen) begin
                case (aw_addr[3:2])
                    `GEN_LOAD: load_v[gen_base +: WIDTH] <=
                        (load_v[gen_base +: WIDTH] & ~w_mask[WIDTH-1:0]) | w_lane[WIDTH-1:0];
                    `GEN_CMPA: cmpa_v[gen_base +: WIDTH] <=
                        (cmpa_v[gen_base +: WIDTH] & ~w_mask[WIDTH-1:0]) | w_lane[WIDTH-1:0];
                    `GEN_CMPB: cmpb_v[gen_base +: WIDTH] <=
                        (cmpb_v[gen_base +: WIDTH] & ~w_mask[WIDTH-1:0]) | w_lane[WIDTH-1:0];
                    default: begin
                        rise_v[gen_base +: WIDTH] <=
                            (rise_v[gen_base +: WIDTH] & ~w_mask[15:0]) | w_lane[15:0];
                        fall_v[gen_base +: WIDTH] <=
                            (fall_v[gen_base +: WIDTH] & ~w_mask[31:16]) | w_lane[31:16];
                    end
                endcase
            end
        end
    end

    // fault interrupt status: set wins over a clear in the same cycle
    wire ext_mode = ctrl[`CTRL_EXT_BIT];
    wire [3:0] clr_bits = (do_write && aw_addr == `OFS_FAULT_STAT) ? w_lane[3:0] :
        (do_write && aw_addr == `OFS_FAULT_CLR0) ? 4'h1 : 4'h0;
    reg [3:0] fault_src;
    integer f;
    always @* begin
        fault_src = 4'h0;
        if (ext_mode) begin
            for (f = 0; f < NUM_GEN; f = f + 1) begin
                fault_src[f] = |(external_fault_input & trig_sel[4*f +: 4]);
            end
        end else begin
            fault_src[0] = external_fault_input[0];
        end
    end
    wire [3:0] next_fault_stat = (fault_stat & ~clr_bits) | fault_src;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fault_stat <= 4'h0;
            fault_pending <= 1'b0;
        end else begin
            fault_stat <= next_fault_stat;
            fault_pending <= |next_fault_stat;
        end
    end

    // generators
    genvar g;
    generate
        for (g = 0; g < NUM_GEN; g = g + 1) begin : gen_slot
            pwm_counter_gen #(.WIDTH(WIDTH)) counter_i (
                .clk(clk),
                .rstn(rstn),
                .enable(ctrl[`CTRL_EN_LSB + g]),
                .up_down(ctrl[`CTRL_UPDN_LSB + g]),
                .sync_mode(ctrl[`CTRL_SYNC_LSB + g]),
                .sync_pulse(sync_pulse[g]),
                .load_in(load_v[WIDTH*g +: WIDTH]),
                .cmpa_in(cmpa_v[WIDTH*g +: WIDTH]),
                .cmpb_in(cmpb_v[WIDTH*g +: WIDTH]),
                .count(count_v[WIDTH*g +: WIDTH]),
                .cmp_a_out(cmp_a[g]),
                .cmp_b_out(cmp_b[g]),
                .zero_pulse(gen_trigger[g])
            );
            pwm_dead_band #(.WIDTH(WIDTH)) dead_band_i (
                .clk(clk),
                .rstn(rstn),
                .db_enable(ctrl[`CTRL_DB_LSB + g]),
                .rise_delay(rise_v[WIDTH*g +: WIDTH]),
                .fall_delay(fall_v[WIDTH*g +: WIDTH]),
                .src_a(cmp_a[g]),
                .src_b(cmp_b[g]),
                .first_pair_output(pair_raw[2*g]),
                .second_pair_output(pair_raw[2*g+1])
            );
            // the trigger pulse doubles as the generator's own interrupt line
            assign gen_interrupt[g] = gen_trigger[g];
        end
    endgenerate

    // output control
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pulse_out <= {2*NUM_GEN{1'b0}};
        end else begin
            pulse_out <= out_en & (pair_raw ^ invert);
        end
    end

    // read channel: one cycle from address to data
    reg [31:0] rd_word;
    wire [5:0] rd_base = {s_axi_araddr[5:4], 4'h0};
    wire [5:0] cnt_base = {s_axi_araddr[3:2], 4'h0};
    always @* begin
        rd_word = 32'h00000000;
        if (s_axi_araddr >= `OFS_GEN_BASE) begin
            case (s_axi_araddr[3:2])
                `GEN_LOAD: rd_word = {16'h0000, load_v[rd_base +: WIDTH]};
                `GEN_CMPA: rd_word = {16'h0000, cmpa_v[rd_base +: WIDTH]};
                `GEN_CMPB: rd_word = {16'h0000, cmpb_v[rd_base +: WIDTH]};
                default: rd_word = {fall_v[rd_base +: WIDTH], rise_v[rd_base +: WIDTH]};
            endcase
        end else if (s_axi_araddr >= `OFS_COUNT_BASE) begin
            rd_word = {16'h0000, count_v[cnt_base +: WIDTH]};
        end else begin
            case (s_axi_araddr)
                `OFS_CTRL: rd_word = {15'h0000, ctrl};
                `OFS_INVERT: rd_word = {24'h000000, invert};
                `OFS_OUT_EN: rd_word = {24'h000000, out_en};
                `OFS_FAULT_STAT: rd_word = {28'h0000000, fault_stat};
                `OFS_TRIG_SEL: rd_word = {16'h0000, trig_sel};
                default: rd_word = 32'h00000000;
            endcase
        end
        if (!addr_mapped(s_axi_araddr)) begin
            rd_word = 32'h00000000;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= addr_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ### rtl/pwm_unit_defs.vh
`ifndef PWM_UNIT_DEFS_VH
`define PWM_UNIT_DEFS_VH

// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_SYNC 8'h04
`define OFS_INVERT 8'h08
`define OFS_OUT_EN 8'h0c
`define OFS_FAULT_STAT 8'h10
`define OFS_FAULT_CLR0 8'h14
`define OFS_TRIG_SEL 8'h18
`define OFS_COUNT_BASE 8'h20
`define OFS_GEN_BASE 8'h40
`define OFS_GEN_LAST 8'h7c

// per-generator word index inside its 16-byte block
`define GEN_LOAD 2'd0
`define GEN_CMPA 2'd1
`define GEN_CMPB 2'd2
`define GEN_DEAD 2'd3

// control field positions
`define CTRL_EN_LSB 0
`define CTRL_DB_LSB 4
`define CTRL_UPDN_LSB 8
`define CTRL_SYNC_LSB 12
`define CTRL_EXT_BIT 16
`define CTRL_WIDTH 17

// reset values
`define RST_CTRL 17'h00000
`define RST_INVERT 8'h00
`define RST_OUT_EN 8'h00
`define RST_TRIG_SEL 16'h0000
`define RST_WORD16 16'h0000

// bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ### rtl/pwm_counter_gen.v
`timescale 1ns/1ps
`default_nettype none
module pwm_counter_gen #(
    parameter WIDTH = 16
) (
    // clock and reset
    input wire clk,
    input wire rstn,
    // configuration
    input wire enable,
    input wire up_down,
    input wire sync_mode,
    input wire sync_pulse,
    input wire [WIDTH-1:0] load_in,
    input wire [WIDTH-1:0] cmpa_in,
    input wire [WIDTH-1:0] cmpb_in,
    // results
    output reg [WIDTH-1:0] count,
    output reg cmp_a_out,
    output reg cmp_b_out,
    output reg zero_pulse
);
    reg [WIDTH-1:0] load_act, cmpa_act, cmpb_act;
    reg [WIDTH-1:0] load_stg, cmpa_stg, cmpb_stg;
    reg pending;
    reg count_up;
    wire at_zero = (count == {WIDTH{1'b0}});

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            load_stg <= {WIDTH{1'b0}};
            cmpa_stg <= {WIDTH{1'b0}};
            cmpb_stg <= {WIDTH{1'b0}};
            pending <= 1'b0;
            load_act <= {WIDTH{1'b0}};
            cmpa_act <= {WIDTH{1'b0}};
            cmpb_act <= {WIDTH{1'b0}};
        end else begin
            // sync mode freezes a snapshot at the sync event
            if (!sync_mode || sync_pulse) begin
                load_stg <= load_in;
                cmpa_stg <= cmpa_in;
                cmpb_stg <= cmpb_in;
            end
            if (sync_mode && sync_pulse) begin
                pending <= 1'b1;
            end else if (at_zero && (!sync_mode || pending)) begin
                pending <= 1'b0;
            end
            if (at_zero && (!sync_mode || pending)) begin
                load_act <= load_stg;
                cmpa_act <= cmpa_stg;
                cmpb_act <= cmpb_stg;
            end
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count <= {WIDTH{1'b0}};
            count_up <= 1'b1;
            cmp_a_out <= 1'b0;
            cmp_b_out <= 1'b0;
            zero_pulse <= 1'b0;
        end else begin
            zero_pulse <= 1'b0;
            if (enable) begin
                zero_pulse <= at_zero;
                if (!up_down) begin
                    count <= at_zero ? load_act : count - 1'b1;
                    count_up <= 1'b1;
                end else if (count_up) begin
                    if (count >= load_act) begin
                        count_up <= 1'b0;
                        count <= at_zero ? count : count - 1'b1;
                    end else begin
                        count <= count + 1'b1;
                    end
                end else if (at_zero) begin
                    count_up <= 1'b1;
                    count <= (load_act == {WIDTH{1'b0}}) ? count : count + 1'b1;
                end else begin
                    count <= count - 1'b1;
                end
                // left aligned in down mode, center aligned in up/down
                cmp_a_out <= up_down ? (count < cmpa_act) : (count > cmpa_act);
                cmp_b_out <= up_down ? (count < cmpb_act) : (count > cmpb_act);
            end
        end
    end
endmodule
`default_nettype wire

// ### rtl/pwm_dead_band.v
`timescale 1ns/1ps
`default_nettype none
module pwm_dead_band #(
    parameter WIDTH = 16
) (
    // clock and reset
    input wire clk,
    input wire rstn,
    // control
    input wire db_enable,
    input wire [WIDTH-1:0] rise_delay,
    input wire [WIDTH-1:0] fall_delay,
    // waveforms from the comparators
    input wire src_a,
    input wire src_b,
    // pair outputs
    output reg first_pair_output,
    output reg second_pair_output
);
    reg [WIDTH-1:0] high_run, low_run;
    wire high_sat = &high_run;
    wire low_sat = &low_run;

    // cycles the source has stayed high or low, saturating
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            high_run <= {WIDTH{1'b0}};
            low_run <= {WIDTH{1'b0}};
            first_pair_output <= 1'b0;
            second_pair_output <= 1'b0;
        end else begin
            high_run <= src_a ? (high_sat ? high_run : high_run + 1'b1) : {WIDTH{1'b0}};
            low_run <= src_a ? {WIDTH{1'b0}} : (low_sat ? low_run : low_run + 1'b1);
            if (db_enable) begin
                first_pair_output <= src_a && (high_run >= rise_delay);
                second_pair_output <= !src_a && (low_run >= fall_delay);
            end else begin
                first_pair_output <= src_a;
                second_pair_output <= src_b;
            end
        end
    end
endmodule
`default_nettype wire

// ### verification/pwm_power_stage.sv
`timescale 1ns/1ps
`default_nettype none
module pwm_power_stage (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // gate drive and commanded trips
    input wire logic [7:0] gate,
    input wire logic [3:0] trip,
    // fault sense back to the unit, and a count of leg 0 overlaps for the testbench
    output logic [3:0] fault_line,
    output int overlap
);
    // a leg with both switches on is a short, sensed as a fault on that leg
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fault_line <= 4'h0;
            overlap <= 0;
        end else begin
            for (int n = 0; n < 4; n++) begin
                fault_line[n] <= trip[n] | (gate[2*n] & gate[2*n+1]);
            end
            if (gate[0] & gate[1]) begin
                overlap <= overlap + 1;
            end
        end
    end
endmodule
`default_nettype wire

// ### verification/pwm_unit_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pwm_unit_properties #(
    parameter NUM_GEN = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // events
    input wire logic [NUM_GEN-1:0] gen_interrupt,
    input wire logic [NUM_GEN-1:0] gen_trigger,
    input wire logic fault_pending
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_aw_ready_drop: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("awready stayed high after a handshake");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    a_irq_trig_same: assert property (gen_interrupt == gen_trigger)
        else $error("interrupt and trigger differ");
    a_trigger_single: assert property (gen_trigger[0] |=> !gen_trigger[0])
        else $error("trigger longer than one cycle");
    a_fault_sticky: assert property ($fell(fault_pending) |-> $rose(s_axi_bvalid))
        else $error("fault pending fell without a write");
endmodule
bind pwm_unit pwm_unit_properties #(.NUM_GEN(NUM_GEN)) i_pwm_unit_properties (.clk(clk), .rstn(rstn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .gen_interrupt(gen_interrupt), .gen_trigger(gen_trigger), .fault_pending(fault_pending));
`default_nettype wire

// ### verification/pwm_unit_tb_top.sv
`timescale 1ns/1ps
`include "pwm_unit_defs.vh"
`default_nettype none
module pwm_unit_tb_top;
    logic clk = 1'b0, rstn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, pulse_out;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, fault_pending;
    logic [1:0] bresp, rresp;
    logic [3:0] trip = 4'h0, ext_fault, gen_interrupt, gen_trigger;
    int n_fail = 0, comparisons = 0, hc[8], ov, p;

    always #4 clk = ~clk;

    pwm_unit i_pwm_unit (.clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .external_fault_input(ext_fault),
        .pulse_out(pulse_out), .gen_interrupt(gen_interrupt), .gen_trigger(gen_trigger),
        .fault_pending(fault_pending));
    pwm_power_stage i_pwm_power_stage (.clk(clk), .rstn(rstn), .gate(pulse_out), .trip(trip),
        .fault_line(ext_fault), .overlap(ov));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = `RESP_OKAY);
        bit ad = 0, wd = 0;
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (ad && wd && bvalid) break;
            if (!ad && awready) begin awvalid <= 1'b0; ad = 1; end
            if (!wd && wready) begin wvalid <= 1'b0; wd = 1; end
        end
        // bready stays up so a following write never drives it twice in one step
        chk({30'h0, bresp}, {30'h0, er}, "bresp");
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = `RESP_OKAY);
        bit ad = 0;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (ad && rvalid) break;
            if (!ad && arready) begin arvalid <= 1'b0; ad = 1; end
        end
        chk({30'h0, rresp}, {30'h0, er}, "rresp");
        chk(rdata, exp, "rdata");
    endtask

    // cycles from one zero of generator 0 to the next
    task automatic period();
        p = 0;
        while (gen_trigger[0] !== 1'b1) @(posedge clk);
        do begin @(posedge clk); p++; end while (gen_trigger[0] !== 1'b1);
    endtask

    task automatic count_high(input int cycles);
        for (int b = 0; b < 8; b++) hc[b] = 0;
        repeat (cycles) begin
            @(posedge clk);
            for (int b = 0; b < 8; b++) hc[b] += (pulse_out[b] === 1'b1);
        end
    endtask

    task automatic pulse_trip(input logic [3:0] v);
        trip <= v;
        repeat (3) @(posedge clk);
        trip <= 4'h0;
        repeat (4) @(posedge clk);
    endtask

    task automatic t_regs();
        rd(`OFS_CTRL, 32'h0);
        rd(`OFS_OUT_EN, 32'h0);
        rd(`OFS_FAULT_STAT, 32'h0);
        rd(8'h1c, 32'h0, `RESP_SLVERR);
        rd(8'h02, 32'h0, `RESP_SLVERR);
        wr(8'h1c, 32'h1, `RESP_SLVERR);
        wr(`OFS_INVERT, 32'h1ff);
        rd(`OFS_INVERT, 32'hff);
        $display("test regs done");
    endtask

    task automatic t_count();
        wr(`OFS_GEN_BASE, 32'h5);
        wr(`OFS_CTRL, 32'h1);
        period(); chk(p, 6, "down period");
        wr(`OFS_CTRL, 32'h101);
        period(); period(); chk(p, 10, "up/down period");
        wr(`OFS_CTRL, 32'h1001);
        wr(`OFS_GEN_BASE, 32'h9);
        period(); period(); chk(p, 6, "held load");
        wr(`OFS_SYNC, 32'h1);
        // the zero that applies the held load still reloads the old one
        period(); period(); period(); chk(p, 10, "synced load");
        wr(`OFS_CTRL, 32'h0);
        p = 0;
        repeat (30) begin @(posedge clk); p += (gen_trigger[0] === 1'b1); end
        chk(p, 0, "disabled triggers");
        $display("test count done");
    endtask

    task automatic t_pins();
        wr(`OFS_GEN_BASE + 8'h4, 32'h1);
        wr(`OFS_GEN_BASE + 8'h8, 32'h3);
        wr(`OFS_GEN_BASE + 8'hc, 32'h0001_0001);
        wr(`OFS_GEN_BASE, 32'h5);
        wr(`OFS_INVERT, 32'h0c);
        wr(`OFS_OUT_EN, 32'h03);
        wr(`OFS_CTRL, 32'h1);
        repeat (30) @(posedge clk);
        count_high(12);
        chk(hc[0], 8, "first");
        chk(hc[1], 4, "second");
        chk(hc[2] + hc[3], 0, "blocked pins");
        wr(`OFS_INVERT, 32'h01);
        repeat (4) @(posedge clk);
        count_high(12);
        chk(hc[0], 4, "inverted");
        wr(`OFS_INVERT, 32'h0);
        wr(`OFS_CTRL, 32'h11);
        repeat (12) @(posedge clk);
        p = ov;
        count_high(12);
        chk(hc[0], 6, "db first");
        chk(hc[1], 2, "db second");
        chk(ov - p, 0, "overlap");
        wr(`OFS_CTRL, 32'h1);
        repeat (4) @(posedge clk);
        count_high(12);
        chk(hc[1], 4, "decoupled");
        $display("test pins done");
    endtask

    task automatic t_fault();
        wr(`OFS_CTRL, 32'h0);
        wr(`OFS_OUT_EN, 32'h0);
        wr(`OFS_FAULT_STAT, 32'hf);
        pulse_trip(4'h1);
        rd(`OFS_FAULT_STAT, 32'h1);
        chk(fault_pending, 1'b1, "pending");
        pulse_trip(4'h2);
        rd(`OFS_FAULT_STAT, 32'h1);
        wr(`OFS_FAULT_CLR0, 32'h0);
        rd(`OFS_FAULT_STAT, 32'h0);
        wr(`OFS_TRIG_SEL, 32'h3040);
        wr(`OFS_CTRL, 32'h10000);
        pulse_trip(4'h5);
        rd(`OFS_FAULT_STAT, 32'ha);
        wr(`OFS_FAULT_CLR0, 32'h0);
        rd(`OFS_FAULT_STAT, 32'ha);
        wr(`OFS_FAULT_STAT, 32'h8);
        rd(`OFS_FAULT_STAT, 32'h2);
        wr(`OFS_FAULT_STAT, 32'h2);
        rd(`OFS_FAULT_STAT, 32'h0);
        repeat (2) @(posedge clk);
        chk(fault_pending, 1'b0, "pending cleared");
        $display("test fault done");
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_regs();
        t_count();
        t_pins();
        t_fault();
        wrap_up();
    end

    initial begin
        #200000;
        n_fail++;
        wrap_up();
    end
endmodule
`default_nettype wire
